/* mpg_pkg.sv */
package mpg_pkg;

  // register indices as printed; the byte address is four times the index
  localparam logic [31:0] MPG_IDX_PORT_H      = 32'h0400_012E;
  localparam logic [31:0] MPG_IDX_PORT_J      = 32'h0400_0130;
  localparam logic [31:0] MPG_IDX_PORT_K      = 32'h0400_0132;
  localparam logic [31:0] MPG_IDX_PORT_L      = 32'h0400_0134;
  localparam logic [31:0] MPG_IDX_SERIAL_SIDE = 32'h0400_0136;

  localparam logic [7:0]  MPG_RST_DATA        = 8'h00;
  localparam logic [7:0]  MPG_RST_OE_N        = 8'hFF;
  localparam logic [7:0]  MPG_RST_PU          = 8'h00;
  localparam logic [39:0] MPG_RST_SYNC        = 40'h00_0000_0000;

  // port H: only pin 7 holds a stored bit; serial side: pins 6 to 0
  localparam int          MPG_H_STORE_BIT     = 7;
  localparam logic [7:0]  MPG_SCP_STORE_MASK  = 8'h7F;
  localparam int          MPG_SCP_IN_BIT      = 7;

  localparam logic [1:0]  MPG_MD_ALT          = 2'b00;
  localparam logic [1:0]  MPG_MD_OUT          = 2'b01;
  localparam logic [1:0]  MPG_MD_IN_PU        = 2'b10;
  localparam logic [1:0]  MPG_MD_IN_NOPU      = 2'b11;

  localparam logic [1:0]  MPG_RESP_OKAY       = 2'b00;
  localparam logic [1:0]  MPG_RESP_SLVERR     = 2'b10;

  // per-pin mode, pin n at bits [2n+1:2n]
  typedef logic [15:0] mpg_mode_t;

  typedef struct packed {
    logic [7:0] lvl;
    logic [7:0] oe_n;
    logic [7:0] pu;
  } mpg_pad_t;

  typedef enum logic [5:0] {
    MPG_SEL_NONE = 6'b000001,
    MPG_SEL_H    = 6'b000010,
    MPG_SEL_J    = 6'b000100,
    MPG_SEL_K    = 6'b001000,
    MPG_SEL_L    = 6'b010000,
    MPG_SEL_SCP  = 6'b100000
  } mpg_sel_t;

endpackage : mpg_pkg

/* mpg_sync.sv */
`timescale 1ns/1ps
module mpg_sync
  import mpg_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // raw pin levels and filtered result
  input  wire logic [39:0] raw,
  output logic      [39:0] lvl
);

  logic [39:0] s1_q;
  logic [39:0] s2_q;
  logic [39:0] s3_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= MPG_RST_SYNC;
      s2_q <= MPG_RST_SYNC;
      s3_q <= MPG_RST_SYNC;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit only changes once the second and third stage agree
  genvar i;
  generate
    for (i = 0; i < 40; i++) begin : g_flt
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          lvl[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          lvl[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule : mpg_sync

/* mpg_gpio_regs.sv */
`timescale 1ns/1ps
// Function
// - port H pin 7: write stores, drives pin in output mode; input modes read pin
// - port H pins 6..0: read low except input modes; writes dropped
// - mode 00 alternate, 01 output, 10 input pull-up, 11 input no pull-up
// - port J reads stored bit in output, pin level in input; bit n is pin n
// - port J writes with byte lane 0 store in every mode; pin driven only in output mode
// - port J data clears on power-on reset, kept otherwise
// - port K behaves like port J for reads and writes
// - port K data clears on power-on reset or hardware standby
// - port L input only: modes 00/01 read zero, 10/11 pin; writes dropped
// - serial-side bits 6..0 writable like port J, bit 7 read-only
// - serial-side bit 7 reads low unless input mode; writes ignored
// - serial-side data clears on power-on reset or hardware standby
// - pull-up enables follow pin-function controller modes, not data register
// - registers are one byte wide, bit n maps to pin n
module mpg_gpio_regs
  import mpg_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // hardware standby request, same clock domain
  input  wire logic        hw_standby,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pin modes from the pin-function controller
  input  mpg_pkg::mpg_mode_t port_h_mode,
  input  mpg_pkg::mpg_mode_t port_j_mode,
  input  mpg_pkg::mpg_mode_t port_k_mode,
  input  mpg_pkg::mpg_mode_t port_l_mode,
  input  mpg_pkg::mpg_mode_t serial_side_mode,
  // pin levels seen at the pads
  input  wire logic [7:0]  port_h_pin_in,
  input  wire logic [7:0]  port_j_pin_in,
  input  wire logic [7:0]  port_k_pin_in,
  input  wire logic [7:0]  port_l_pin_in,
  input  wire logic [7:0]  serial_side_pin_in,
  // pad drive: level, output enable (low drives), pull-up enable
  output mpg_pkg::mpg_pad_t port_h_pad,
  output mpg_pkg::mpg_pad_t port_j_pad,
  output mpg_pkg::mpg_pad_t port_k_pad,
  output mpg_pkg::mpg_pad_t serial_side_pad
);

  // address bits 1:0 are ignored; every register sits in a word of its own
  function automatic mpg_sel_t decode(input logic [31:0] addr);
    logic [29:0] idx;
    idx = addr[31:2];
    if (idx == MPG_IDX_PORT_H[29:0])           decode = MPG_SEL_H;
    else if (idx == MPG_IDX_PORT_J[29:0])      decode = MPG_SEL_J;
    else if (idx == MPG_IDX_PORT_K[29:0])      decode = MPG_SEL_K;
    else if (idx == MPG_IDX_PORT_L[29:0])      decode = MPG_SEL_L;
    else if (idx == MPG_IDX_SERIAL_SIDE[29:0]) decode = MPG_SEL_SCP;
    else                                       decode = MPG_SEL_NONE;
  endfunction : decode

  // read of a pin that has a stored bit
  function automatic logic rd_stored(input logic [1:0] md, input logic st, input logic pin);
    rd_stored = md[1] ? pin : st;
  endfunction : rd_stored

  // read of a pin with no stored bit: low outside the input modes
  function automatic logic rd_input(input logic [1:0] md, input logic pin);
    rd_input = md[1] ? pin : 1'b0;
  endfunction : rd_input

  logic [39:0] pin_lvl;
  logic [7:0]  h_lvl;
  logic [7:0]  j_lvl;
  logic [7:0]  k_lvl;
  logic [7:0]  l_lvl;
  logic [7:0]  s_lvl;

  // pins are filtered before any read sees them; a change shows up four
  // edges later, which bounds how fast software can usefully poll a pin
  mpg_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     ({serial_side_pin_in, port_l_pin_in, port_k_pin_in,
               port_j_pin_in, port_h_pin_in}),
    .lvl     (pin_lvl)
  );

  assign h_lvl = pin_lvl[7:0];
  assign j_lvl = pin_lvl[15:8];
  assign k_lvl = pin_lvl[23:16];
  assign l_lvl = pin_lvl[31:24];
  assign s_lvl = pin_lvl[39:32];

  logic [7:0] h_data_q;
  logic [7:0] j_data_q;
  logic [7:0] k_data_q;
  logic [7:0] s_data_q;

  // write channel state
  logic        aw_full_q;
  logic        w_full_q;
  logic [31:0] aw_addr_q;
  logic [7:0]  w_byte_q;
  logic        w_lane0_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        do_write;
  mpg_sel_t    wsel;

  // one write at a time: both readies stay low until the response is taken
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wsel     = decode(aw_addr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      awready_q <= 1'b1;
    end else if (s_axi_awvalid && awready_q) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      awready_q <= 1'b0;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q  <= 1'b0;
      w_byte_q  <= 8'h00;
      w_lane0_q <= 1'b0;
      wready_q  <= 1'b1;
    end else if (s_axi_wvalid && wready_q) begin
      w_full_q  <= 1'b1;
      w_byte_q  <= s_axi_wdata[7:0];
      w_lane0_q <= s_axi_wstrb[0];
      wready_q  <= 1'b0;
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= MPG_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wsel == MPG_SEL_NONE) ? MPG_RESP_SLVERR : MPG_RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // only byte lane 0 carries data; registers are one byte wide
  logic wr_en;
  assign wr_en = do_write && w_lane0_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_data_q <= MPG_RST_DATA;
    end else if (wr_en && wsel == MPG_SEL_H) begin
      h_data_q[MPG_H_STORE_BIT] <= w_byte_q[MPG_H_STORE_BIT];
    end
  end

  // only power-on reset clears port J; hardware standby leaves it alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      j_data_q <= MPG_RST_DATA;
    end else if (wr_en && wsel == MPG_SEL_J) begin
      j_data_q <= w_byte_q;
    end
  end

  // standby outranks a write that lands in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      k_data_q <= MPG_RST_DATA;
    end else if (wr_en && wsel == MPG_SEL_K) begin
      k_data_q <= w_byte_q;
    end
  end

  // bit 7 never stores, so it stays at its reset value
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      s_data_q <= MPG_RST_DATA;
    end else if (wr_en && wsel == MPG_SEL_SCP) begin
      s_data_q <= w_byte_q & MPG_SCP_STORE_MASK;
    end
  end

  // read value assembly, one bit per pin
  logic [7:0] h_rd;
  logic [7:0] j_rd;
  logic [7:0] k_rd;
  logic [7:0] l_rd;
  logic [7:0] s_rd;

  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_rd
      if (n == MPG_H_STORE_BIT) begin : g_h7
        assign h_rd[n] = rd_stored(port_h_mode[2*n+1:2*n], h_data_q[n], h_lvl[n]);
      end else begin : g_hin
        assign h_rd[n] = rd_input(port_h_mode[2*n+1:2*n], h_lvl[n]);
      end
      assign j_rd[n] = rd_stored(port_j_mode[2*n+1:2*n], j_data_q[n], j_lvl[n]);
      assign k_rd[n] = rd_stored(port_k_mode[2*n+1:2*n], k_data_q[n], k_lvl[n]);
      assign l_rd[n] = rd_input(port_l_mode[2*n+1:2*n], l_lvl[n]);
      if (n == MPG_SCP_IN_BIT) begin : g_s7
        assign s_rd[n] = rd_input(serial_side_mode[2*n+1:2*n], s_lvl[n]);
      end else begin : g_sio
        assign s_rd[n] = rd_stored(serial_side_mode[2*n+1:2*n], s_data_q[n], s_lvl[n]);
      end
    end
  endgenerate

  // read channel
  // the byte is frozen at the address handshake, so a pin that moves while
  // rvalid waits for rready cannot tear the returned value
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  rd_byte;
  mpg_sel_t    rsel;

  assign rsel = decode(s_axi_araddr);

  always_comb begin
    rd_byte = 8'h00;
    case (rsel)
      MPG_SEL_H:   rd_byte = h_rd;
      MPG_SEL_J:   rd_byte = j_rd;
      MPG_SEL_K:   rd_byte = k_rd;
      MPG_SEL_L:   rd_byte = l_rd;
      MPG_SEL_SCP: rd_byte = s_rd;
      default:     rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= MPG_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rd_byte};
      rresp_q   <= (rsel == MPG_SEL_NONE) ? MPG_RESP_SLVERR : MPG_RESP_OKAY;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // pad drive, registered so that every pad output comes from a flop
  // port l is input only and so has no pad drive at all
  mpg_pad_t h_pad_q;
  mpg_pad_t j_pad_q;
  mpg_pad_t k_pad_q;
  mpg_pad_t s_pad_q;

  generate
    for (n = 0; n < 8; n++) begin : g_pad
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          h_pad_q.lvl[n]  <= MPG_RST_DATA[n];
          h_pad_q.oe_n[n] <= MPG_RST_OE_N[n];
          h_pad_q.pu[n]   <= MPG_RST_PU[n];
          j_pad_q.lvl[n]  <= MPG_RST_DATA[n];
          j_pad_q.oe_n[n] <= MPG_RST_OE_N[n];
          j_pad_q.pu[n]   <= MPG_RST_PU[n];
          k_pad_q.lvl[n]  <= MPG_RST_DATA[n];
          k_pad_q.oe_n[n] <= MPG_RST_OE_N[n];
          k_pad_q.pu[n]   <= MPG_RST_PU[n];
          s_pad_q.lvl[n]  <= MPG_RST_DATA[n];
          s_pad_q.oe_n[n] <= MPG_RST_OE_N[n];
          s_pad_q.pu[n]   <= MPG_RST_PU[n];
        end else begin
          // port H can drive only pin 7 and the serial side only pins 6..0; ports J and K can drive every pin
          h_pad_q.lvl[n]  <= h_data_q[n];
          h_pad_q.oe_n[n] <= !(n == MPG_H_STORE_BIT &&
                               port_h_mode[2*n+1:2*n] == MPG_MD_OUT);
          h_pad_q.pu[n]   <= port_h_mode[2*n+1:2*n] == MPG_MD_IN_PU;
          j_pad_q.lvl[n]  <= j_data_q[n];
          j_pad_q.oe_n[n] <= port_j_mode[2*n+1:2*n] != MPG_MD_OUT;
          j_pad_q.pu[n]   <= port_j_mode[2*n+1:2*n] == MPG_MD_IN_PU;
          k_pad_q.lvl[n]  <= k_data_q[n];
          k_pad_q.oe_n[n] <= port_k_mode[2*n+1:2*n] != MPG_MD_OUT;
          k_pad_q.pu[n]   <= port_k_mode[2*n+1:2*n] == MPG_MD_IN_PU;
          s_pad_q.lvl[n]  <= s_data_q[n];
          s_pad_q.oe_n[n] <= !(n != MPG_SCP_IN_BIT &&
                               serial_side_mode[2*n+1:2*n] == MPG_MD_OUT);
          s_pad_q.pu[n]   <= serial_side_mode[2*n+1:2*n] == MPG_MD_IN_PU;
        end
      end
    end
  endgenerate

  assign s_axi_awready   = awready_q;
  assign s_axi_wready    = wready_q;
  assign s_axi_bvalid    = bvalid_q;
  assign s_axi_bresp     = bresp_q;
  assign s_axi_arready   = arready_q;
  assign s_axi_rvalid    = rvalid_q;
  assign s_axi_rdata     = rdata_q;
  assign s_axi_rresp     = rresp_q;
  assign port_h_pad      = h_pad_q;
  assign port_j_pad      = j_pad_q;
  assign port_k_pad      = k_pad_q;
  assign serial_side_pad = s_pad_q;

endmodule : mpg_gpio_regs

/* mpg_gpio_regs_asserts.sv */
`timescale 1ns/1ps
module mpg_gpio_regs_asserts
  import mpg_pkg::*;
(
  // clock and reset
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         hw_standby,
  // bus handshakes
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic         s_axi_rvalid,
  input wire logic [31:0]  s_axi_rdata,
  // modes and pads
  input mpg_pkg::mpg_mode_t port_h_mode,
  input mpg_pkg::mpg_mode_t port_j_mode,
  input mpg_pkg::mpg_mode_t port_k_mode,
  input mpg_pkg::mpg_pad_t  port_h_pad,
  input mpg_pkg::mpg_pad_t  port_j_pad,
  input mpg_pkg::mpg_pad_t  port_k_pad,
  input mpg_pkg::mpg_pad_t  serial_side_pad
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  j_drive_on_a: assert property (port_j_mode[1:0] == MPG_MD_OUT |=> !port_j_pad.oe_n[0])
    else $error("port j pin 0 not driven in output mode");
  j_drive_off_a: assert property (port_j_mode[1:0] != MPG_MD_OUT |=> port_j_pad.oe_n[0])
    else $error("port j pin 0 driven outside output mode");
  h7_drive_a: assert property (port_h_mode[15:14] == MPG_MD_OUT |=> !port_h_pad.oe_n[7])
    else $error("port h pin 7 not driven in output mode");
  h_low_quiet_a: assert property (port_h_pad.oe_n[6:0] == 7'h7F)
    else $error("port h low pins driven");
  scp7_quiet_a: assert property (serial_side_pad.oe_n[7])
    else $error("serial side pin 7 driven");
  k_pullup_a: assert property (port_k_mode[3:2] == MPG_MD_IN_PU |=> port_k_pad.pu[1])
    else $error("port k pin 1 pull-up off in pull-up mode");
  k_standby_a: assert property (hw_standby [*2] |=> port_k_pad.lvl == 8'h00)
    else $error("port k data kept through standby");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response timing wrong");
  rd_byte_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read answer late or wider than a byte");
endmodule : mpg_gpio_regs_asserts

bind mpg_gpio_regs mpg_gpio_regs_asserts i_chk (.aclk, .aresetn, .hw_standby, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rdata, .port_h_mode, .port_j_mode, .port_k_mode, .port_h_pad,
  .port_j_pad, .port_k_pad, .serial_side_pad);

/* mpg_gpio_regs_tb.sv */
`timescale 1ns/1ps
module mpg_gpio_regs_tb;
  import mpg_pkg::*;
  logic        aclk, aresetn, hw_standby;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  mpg_mode_t   port_h_mode, port_j_mode, port_k_mode, port_l_mode, serial_side_mode;
  logic [7:0]  port_h_pin_in, port_j_pin_in, port_k_pin_in, port_l_pin_in, serial_side_pin_in;
  mpg_pad_t    port_h_pad, port_j_pad, port_k_pad, serial_side_pad;
  int          num_errors, checks;
  localparam logic [31:0] A_H = {MPG_IDX_PORT_H[29:0], 2'b00};
  localparam logic [31:0] A_J = {MPG_IDX_PORT_J[29:0], 2'b00};
  localparam logic [31:0] A_K = {MPG_IDX_PORT_K[29:0], 2'b00};
  localparam logic [31:0] A_L = {MPG_IDX_PORT_L[29:0], 2'b00};
  localparam logic [31:0] A_S = {MPG_IDX_SERIAL_SIDE[29:0], 2'b00};
  localparam logic [31:0] A_X = 32'h0000_0100;
  localparam logic [1:0]  OK  = MPG_RESP_OKAY;
  localparam logic [1:0]  ERR = MPG_RESP_SLVERR;

  mpg_gpio_regs i_dut (.aclk, .aresetn, .hw_standby, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_h_mode,
    .port_j_mode, .port_k_mode, .port_l_mode, .serial_side_mode, .port_h_pin_in,
    .port_j_pin_in, .port_k_pin_in, .port_l_pin_in, .serial_side_pin_in, .port_h_pad,
    .port_j_pad, .port_k_pad, .serial_side_pad);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic complete_run();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt

  // bready is held high, so the answer is taken at the edge it is seen
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (s_axi_bvalid !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t write response timeout", $time);
      complete_run();
    end else begin
      chk({30'h0, s_axi_bresp}, {30'h0, er});
    end
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    if (s_axi_rvalid !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t read data timeout", $time);
      complete_run();
    end else begin
      chk(s_axi_rdata, exp);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
    end
  endtask : rd

  initial begin
    aresetn = 1'b0;  hw_standby = 1'b0;  s_axi_awaddr = 32'h0;  s_axi_awprot = 3'h0;
    s_axi_awvalid = 1'b0;  s_axi_wdata = 32'h0;  s_axi_wstrb = 4'hF;  s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;  s_axi_araddr = 32'h0;  s_axi_arprot = 3'h0;  s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;  port_h_mode = 16'h0;  port_j_mode = 16'h0;  port_k_mode = 16'h0;
    port_l_mode = 16'h0;  serial_side_mode = 16'h0;  port_h_pin_in = 8'h5A;
    port_j_pin_in = 8'h3C;  port_k_pin_in = 8'h96;  port_l_pin_in = 8'hE1;
    serial_side_pin_in = 8'hB4;
    wt(3);
    aresetn <= 1'b1;
    wt(6);
    rd(A_H, 32'h0, OK);
    rd(A_J, 32'h0, OK);
    rd(A_K, 32'h0, OK);
    rd(A_L, 32'h0, OK);
    rd(A_S, 32'h0, OK);
    rd(A_X, 32'h0, ERR);
    wr(A_X, 8'hFF, ERR);
    // stored in alternate mode but the pin stays released
    wr(A_J, 8'hA5, OK);
    rd(A_J, 32'hA5, OK);
    chk({24'h0, port_j_pad.oe_n}, 32'hFF);
    port_j_mode <= 16'h5555;
    wt(2);
    chk({8'h00, port_j_pad}, 32'h00A5_0000);
    port_j_mode <= 16'hAAAA;
    wt(6);
    rd(A_J, 32'h3C, OK);
    chk({16'h0, port_j_pad.oe_n, port_j_pad.pu}, 32'hFFFF);
    wr(A_J, 8'h0F, OK);
    port_j_mode <= 16'h5555;
    rd(A_J, 32'h0F, OK);
    chk({8'h00, port_j_pad}, 32'h000F_0000);
    // pins 0/4 no pull-up, 1/5 pull-up, 2/6 output, 3/7 alt; h and serial pin 7 use 01
    port_h_mode      <= 16'h5B1B;
    port_k_mode      <= 16'h1B1B;
    port_l_mode      <= 16'h1B1B;
    serial_side_mode <= 16'h5B1B;
    wr(A_K, 8'hC3, OK);
    wr(A_L, 8'hFF, OK);
    wr(A_H, 8'hFF, OK);
    wr(A_S, 8'hFF, OK);
    wt(6);
    rd(A_K, 32'hD2, OK);
    rd(A_L, 32'h21, OK);
    rd(A_H, 32'h92, OK);
    rd(A_S, 32'h7C, OK);
    chk({8'h00, port_k_pad}, 32'h00C3_BB22);
    chk({15'h0, port_h_pad.lvl[7], port_h_pad.oe_n, port_h_pad.pu}, 32'h1_7F22);
    chk({8'h00, serial_side_pad}, 32'h007F_BB22);
    // standby clears port k and serial side only
    hw_standby <= 1'b1;
    wt(2);
    hw_standby  <= 1'b0;
    port_j_mode <= 16'h0;
    wt(1);
    rd(A_K, 32'h12, OK);
    rd(A_S, 32'h30, OK);
    rd(A_J, 32'h0F, OK);
    rd(A_H, 32'h92, OK);
    // pin 7 of port h and of the serial side now in input mode: the pin is read
    port_h_mode      <= 16'hDB1B;
    serial_side_mode <= 16'hDB1B;
    rd(A_H, 32'h12, OK);
    rd(A_S, 32'hB0, OK);
    aresetn <= 1'b0;
    wt(3);
    aresetn <= 1'b1;
    wt(1);
    rd(A_J, 32'h0, OK);
    // a write without byte lane 0 stores nothing
    s_axi_wstrb <= 4'hE;
    wr(A_J, 8'h55, OK);
    rd(A_J, 32'h0, OK);
    complete_run();
  end
endmodule : mpg_gpio_regs_tb
